// File: rtl/ltld_pkg.sv
// package: register map, field layout and reset values of the lane control bank
// Overview of operation
// - Offset 0x12 holds the receiver termination float bits of banks 0 and 1, bit = channel + 4 * bank.
// - Offset 0x13 holds the receiver termination float bits of bank 2 in bits 3:0 and bank 3 in bits 7:4.
// - A float bit of one puts that lane's input termination in high impedance, zero leaves it off, reset is zero.
// - Offset 0x14 holds the signal-loss detector enables of bank 0 in bits 3:0 and bank 1 in bits 7:4.
// - Offset 0x15 holds the signal-loss detector enables of bank 2 in bits 3:0 and bank 3 in bits 7:4.
// - A signal-loss enable bit of one turns that lane's detector on, zero keeps it off, reset is zero.
// - Bank 0 drive current is a nibble per lane, channels 0-1 at 0x16 and 2-3 at 0x17, lower channel in 3:0.
// - Bank 1 drive current sits at 0x18 for channels 0-1 and 0x19 for channels 2-3, same nibble layout.
// - Bank 2 drive current for channel 0 sits in bits 3:0 and channel 1 in bits 7:4 of offset 0x1A.
// - Every drive current nibble resets to binary 1000, so each two-lane byte resets to 0x88.
package ltld_pkg;

  localparam int unsigned LTLD_NUM_REGS   = 9;
  localparam int unsigned LTLD_DATA_W     = 8;
  localparam int unsigned LTLD_ADDR_W     = 8;
  localparam int unsigned LTLD_LANES      = 4;
  localparam int unsigned LTLD_NIBBLE_W   = 4;

  // register indices inside the bank
  localparam int unsigned LTLD_IDX_HIZ01  = 0;
  localparam int unsigned LTLD_IDX_HIZ23  = 1;
  localparam int unsigned LTLD_IDX_LOS01  = 2;
  localparam int unsigned LTLD_IDX_LOS23  = 3;
  localparam int unsigned LTLD_IDX_DRV00  = 4;
  localparam int unsigned LTLD_IDX_DRV02  = 5;
  localparam int unsigned LTLD_IDX_DRV10  = 6;
  localparam int unsigned LTLD_IDX_DRV12  = 7;
  localparam int unsigned LTLD_IDX_DRV20  = 8;

  // byte offsets on the register port
  localparam logic [7:0] LTLD_OFS_RX_TERM_HIZ_BANKS01  = 8'h12;
  localparam logic [7:0] LTLD_OFS_RX_TERM_HIZ_BANKS23  = 8'h13;
  localparam logic [7:0] LTLD_OFS_SIGLOSS_ENABLE_BANKS01 = 8'h14;
  localparam logic [7:0] LTLD_OFS_SIGLOSS_ENABLE_BANKS23 = 8'h15;
  localparam logic [7:0] LTLD_OFS_TX_DRIVE_B0_CH01     = 8'h16;
  localparam logic [7:0] LTLD_OFS_TX_DRIVE_B0_CH23     = 8'h17;
  localparam logic [7:0] LTLD_OFS_TX_DRIVE_B1_CH01     = 8'h18;
  localparam logic [7:0] LTLD_OFS_TX_DRIVE_B1_CH23     = 8'h19;
  localparam logic [7:0] LTLD_OFS_TX_DRIVE_B2_CH01     = 8'h1A;

  // reset values
  localparam logic [7:0] LTLD_RST_FLAGS   = 8'h00;
  localparam logic [7:0] LTLD_RST_DRIVE   = 8'h88;

  // field positions inside a byte
  localparam int unsigned LTLD_LO_LSB     = 0;
  localparam int unsigned LTLD_HI_LSB     = 4;

  // table ordered by index, entry 0 in the lowest byte
  localparam logic [LTLD_NUM_REGS-1:0][7:0] LTLD_REG_OFFSET = {
    LTLD_OFS_TX_DRIVE_B2_CH01, LTLD_OFS_TX_DRIVE_B1_CH23, LTLD_OFS_TX_DRIVE_B1_CH01,
    LTLD_OFS_TX_DRIVE_B0_CH23, LTLD_OFS_TX_DRIVE_B0_CH01, LTLD_OFS_SIGLOSS_ENABLE_BANKS23,
    LTLD_OFS_SIGLOSS_ENABLE_BANKS01, LTLD_OFS_RX_TERM_HIZ_BANKS23, LTLD_OFS_RX_TERM_HIZ_BANKS01
  };

  localparam logic [LTLD_NUM_REGS-1:0][7:0] LTLD_REG_RESET = {
    LTLD_RST_DRIVE, LTLD_RST_DRIVE, LTLD_RST_DRIVE, LTLD_RST_DRIVE, LTLD_RST_DRIVE,
    LTLD_RST_FLAGS, LTLD_RST_FLAGS, LTLD_RST_FLAGS, LTLD_RST_FLAGS
  };

endpackage : ltld_pkg

// File: rtl/ltld_byte_reg.sv
// one read/write control byte with a constant reset value
`timescale 1ns/1ps
module ltld_byte_reg
  import ltld_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored value
  output logic      [7:0] value_reg
);

  logic [7:0] value_next;

  assign value_next = wr_en ? wr_data : value_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      value_reg <= RESET_VALUE;
    else if (clk_en)
      value_reg <= value_next;
  end

endmodule : ltld_byte_reg

// File: rtl/ltld_regs.sv
// lane termination, signal-loss enable and drive current register bank
`timescale 1ns/1ps
module ltld_regs
  import ltld_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // register port from the serial port engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_rd_valid,
  output logic             reg_addr_err,
  // receiver termination float, one bit per channel
  output logic      [3:0]  rx_term_float_bank0,
  output logic      [3:0]  rx_term_float_bank1,
  output logic      [3:0]  rx_term_float_bank2,
  output logic      [3:0]  rx_term_float_bank3,
  // signal-loss detector enables, one bit per channel
  output logic      [3:0]  sigloss_en_bank0,
  output logic      [3:0]  sigloss_en_bank1,
  output logic      [3:0]  sigloss_en_bank2,
  output logic      [3:0]  sigloss_en_bank3,
  // transmit drive current, one nibble per channel, channel 0 lowest
  output logic      [15:0] tx_drive_bank0,
  output logic      [15:0] tx_drive_bank1,
  output logic      [7:0]  tx_drive_bank2
);

  // lane counts of this slice, derived from the map
  localparam int unsigned FLAG_LANES  = 2 * LTLD_DATA_W;
  localparam int unsigned FLAG_BANKS  = FLAG_LANES / LTLD_LANES;
  localparam int unsigned DRIVE_LANES = 2 * (LTLD_IDX_DRV20 - LTLD_IDX_DRV00 + 1);

  // per-entry decode, storage and read terms
  logic [LTLD_NUM_REGS-1:0]      reg_hit;
  logic [LTLD_NUM_REGS-1:0]      reg_wr_hit;
  logic [LTLD_NUM_REGS-1:0][7:0] reg_value;
  logic [LTLD_NUM_REGS-1:0][7:0] rd_term;
  logic [LTLD_NUM_REGS:0][7:0]   rd_chain;
  logic                          any_hit;
  logic                          any_req;

  // read answer path
  logic [7:0]                    rd_mux;
  logic [7:0]                    rd_data_next;
  logic                          rd_valid_next;
  logic                          addr_err_next;
  logic [7:0]                    reg_rd_data_reg;
  logic                          reg_rd_valid_reg;
  logic                          reg_addr_err_reg;

  // lane views of the stored bytes
  logic [FLAG_LANES-1:0]         float_flat;
  logic [FLAG_LANES-1:0]         sigloss_flat;
  logic [FLAG_BANKS-1:0][3:0]    float_bank;
  logic [FLAG_BANKS-1:0][3:0]    sigloss_bank;
  logic [DRIVE_LANES-1:0][3:0]   drive_lane;

  // one decoded byte per map entry; offsets and resets come from the table
  assign rd_chain[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < LTLD_NUM_REGS; gi++)
    begin : g_reg
      assign reg_hit[gi]      = (reg_addr == LTLD_REG_OFFSET[gi]);
      assign reg_wr_hit[gi]   = reg_wr_en & reg_hit[gi];
      assign rd_term[gi]      = reg_value[gi] & {8{reg_hit[gi]}};
      // and-or chain: at most one term is non-zero since offsets are distinct
      assign rd_chain[gi + 1] = rd_chain[gi] | rd_term[gi];

      ltld_byte_reg #(
        .RESET_VALUE (LTLD_REG_RESET[gi])
      ) u_byte (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .wr_en     (reg_wr_hit[gi]),
        .wr_data   (reg_wr_data),
        .value_reg (reg_value[gi])
      );
    end
  endgenerate

  assign any_hit = |reg_hit;
  assign any_req = reg_rd_en | reg_wr_en;
  assign rd_mux  = rd_chain[LTLD_NUM_REGS];

  // unmapped reads return zero and flag the address; writes to them are dropped
  assign rd_data_next  = reg_rd_en ? rd_mux : reg_rd_data_reg;
  assign rd_valid_next = reg_rd_en & any_hit;
  assign addr_err_next = any_req & ~any_hit;

  // read sees the value before a write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rd_data_reg <= 8'h00;
    else if (clk_en)
      reg_rd_data_reg <= rd_data_next;
  end

  // pulses rebuilt every enabled cycle, so back-to-back reads stay high
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rd_valid_reg <= 1'b0;
    else if (clk_en)
      reg_rd_valid_reg <= rd_valid_next;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_addr_err_reg <= 1'b0;
    else if (clk_en)
      reg_addr_err_reg <= addr_err_next;
  end

  assign reg_rd_data  = reg_rd_data_reg;
  assign reg_rd_valid = reg_rd_valid_reg;
  assign reg_addr_err = reg_addr_err_reg;

  // flag bytes side by side, so a lane's bit is channel + 4 * bank
  assign float_flat   = {reg_value[LTLD_IDX_HIZ23], reg_value[LTLD_IDX_HIZ01]};
  assign sigloss_flat = {reg_value[LTLD_IDX_LOS23], reg_value[LTLD_IDX_LOS01]};

  genvar gb;
  genvar gc;
  generate
    for (gb = 0; gb < FLAG_BANKS; gb++)
    begin : g_bank
      for (gc = 0; gc < LTLD_LANES; gc++)
      begin : g_chan
        assign float_bank[gb][gc]   = float_flat[gc + LTLD_LANES * gb];
        assign sigloss_bank[gb][gc] = sigloss_flat[gc + LTLD_LANES * gb];
      end
    end
  endgenerate

  // termination float per bank
  assign rx_term_float_bank0 = float_bank[0];
  assign rx_term_float_bank1 = float_bank[1];
  assign rx_term_float_bank2 = float_bank[2];
  assign rx_term_float_bank3 = float_bank[3];

  // signal-loss detector enables per bank
  assign sigloss_en_bank0 = sigloss_bank[0];
  assign sigloss_en_bank1 = sigloss_bank[1];
  assign sigloss_en_bank2 = sigloss_bank[2];
  assign sigloss_en_bank3 = sigloss_bank[3];

  // drive nibbles: lane k sits in drive entry k / 2, low nibble for even k
  genvar gk;
  generate
    for (gk = 0; gk < DRIVE_LANES; gk++)
    begin : g_drive
      localparam int unsigned ENTRY = LTLD_IDX_DRV00 + gk / 2;
      localparam int unsigned LSB   = (gk % 2 == 0) ? LTLD_LO_LSB : LTLD_HI_LSB;
      assign drive_lane[gk] = reg_value[ENTRY][LSB +: LTLD_NIBBLE_W];
    end
  endgenerate

  // lower channel always in the lower nibble of each bank word
  assign tx_drive_bank0 = {drive_lane[3], drive_lane[2], drive_lane[1], drive_lane[0]};
  assign tx_drive_bank1 = {drive_lane[7], drive_lane[6], drive_lane[5], drive_lane[4]};
  assign tx_drive_bank2 = {drive_lane[9], drive_lane[8]};

endmodule : ltld_regs

// File: dv/ltld_regs_sva.sv
// checker: write layout, reset values and read flags of the lane control bank
`timescale 1ns/1ps
module ltld_regs_sva
  import ltld_pkg::*;
(
  // clock, reset and enable
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        reg_rd_valid,
  input wire logic        reg_addr_err,
  // lane controls
  input wire logic [3:0]  rx_term_float_bank0,
  input wire logic [3:0]  rx_term_float_bank1,
  input wire logic [3:0]  rx_term_float_bank2,
  input wire logic [3:0]  rx_term_float_bank3,
  input wire logic [3:0]  sigloss_en_bank0,
  input wire logic [3:0]  sigloss_en_bank1,
  input wire logic [3:0]  sigloss_en_bank2,
  input wire logic [3:0]  sigloss_en_bank3,
  input wire logic [15:0] tx_drive_bank0,
  input wire logic [15:0] tx_drive_bank1,
  input wire logic [7:0]  tx_drive_bank2
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic wr_ok = clk_en && reg_wr_en;
  wire logic rd_ok = clk_en && reg_rd_en;
  wire logic mapped = (reg_addr >= 8'h12) && (reg_addr <= 8'h1A);
  a_float_low_pair: assert property (wr_ok && reg_addr == 8'h12
    |=> {rx_term_float_bank1, rx_term_float_bank0} == $past(reg_wr_data)) else $error("float byte 0x12 wrong");
  a_float_high_pair: assert property (wr_ok && reg_addr == 8'h13
    |=> {rx_term_float_bank3, rx_term_float_bank2} == $past(reg_wr_data)) else $error("float byte 0x13 wrong");
  a_sigloss_low_pair: assert property (wr_ok && reg_addr == 8'h14
    |=> {sigloss_en_bank1, sigloss_en_bank0} == $past(reg_wr_data)) else $error("sigloss byte 0x14 wrong");
  a_sigloss_high_pair: assert property (wr_ok && reg_addr == 8'h15
    |=> {sigloss_en_bank3, sigloss_en_bank2} == $past(reg_wr_data)) else $error("sigloss byte 0x15 wrong");
  a_drive_b0_upper: assert property (wr_ok && reg_addr == 8'h17
    |=> tx_drive_bank0[15:8] == $past(reg_wr_data)) else $error("drive byte 0x17 wrong");
  a_drive_b1_lower: assert property (wr_ok && reg_addr == 8'h18
    |=> tx_drive_bank1[7:0] == $past(reg_wr_data)) else $error("drive byte 0x18 wrong");
  a_drive_b2_pair: assert property (wr_ok && reg_addr == 8'h1A
    |=> tx_drive_bank2 == $past(reg_wr_data)) else $error("drive byte 0x1A wrong");
  a_reset_lane_values: assert property ($rose(rst_b) |-> {tx_drive_bank2, tx_drive_bank1, tx_drive_bank0}
    == 40'h8888888888 && {rx_term_float_bank3, rx_term_float_bank2, rx_term_float_bank1, rx_term_float_bank0,
    sigloss_en_bank3, sigloss_en_bank2, sigloss_en_bank1, sigloss_en_bank0} == 32'h0) else $error("reset lanes");
  a_read_hit_flag: assert property (rd_ok && mapped
    |=> reg_rd_valid && !reg_addr_err) else $error("mapped read flags wrong");
  a_valid_only_read: assert property (clk_en && !(rd_ok && mapped)
    |=> !reg_rd_valid) else $error("read valid without a mapped read");
  a_read_miss_zero: assert property (rd_ok && !mapped && !reg_wr_en
    |=> reg_addr_err && !reg_rd_valid && reg_rd_data == 8'h00) else $error("unmapped read answer wrong");
endmodule : ltld_regs_sva

bind ltld_regs ltld_regs_sva sva_u (.*);

// File: dv/ltld_regs_tb_top.sv
// testbench: register port accesses and lane outputs of the control bank
`timescale 1ns/1ps
module ltld_regs_tb_top;
  import ltld_pkg::*;
  localparam logic [7:0] PAT [9] = '{8'h5A, 8'hC3, 8'h81, 8'h24, 8'h3A, 8'h71, 8'hE6, 8'h0F, 8'hB9};
  logic        ref_clk, rst_b, clk_en, reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_err;
  logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, drv2;
  logic [3:0]  flt [4];
  logic [3:0]  sig [4];
  logic [15:0] drv0, drv1;
  logic [7:0]  m [9];
  int          n_errors = 0;
  int          checks = 0;
  // whole lane state in one word so a misplaced nibble shows anywhere
  wire  [71:0] want = {m[1], m[0], m[3], m[2], m[8], m[7], m[6], m[5], m[4]};
  wire  [71:0] lanes = {flt[3], flt[2], flt[1], flt[0], sig[3], sig[2], sig[1], sig[0], drv2, drv1, drv0};

  ltld_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err), .rx_term_float_bank0(flt[0]),
    .rx_term_float_bank1(flt[1]), .rx_term_float_bank2(flt[2]), .rx_term_float_bank3(flt[3]),
    .sigloss_en_bank0(sig[0]), .sigloss_en_bank1(sig[1]), .sigloss_en_bank2(sig[2]),
    .sigloss_en_bank3(sig[3]), .tx_drive_bank0(drv0), .tx_drive_bank1(drv1), .tx_drive_bank2(drv2));

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // leaves the strobe up so consecutive calls write back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    chk("read data", {64'h0, d}, {64'h0, reg_rd_data});
    chk("read flags", {70'h0, ~e, e}, {70'h0, reg_rd_valid, reg_addr_err});
  endtask : rd

  task automatic tally_and_finish();
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    {rst_b, clk_en, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = 20'h40000;
    for (int i = 0; i < 9; i++) m[i] = (i < 4) ? 8'h00 : 8'h88;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("reset lanes", want, lanes);
    for (int i = 0; i < 9; i++) rd(8'h12 + 8'(i), m[i], 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      m[i] = PAT[i];
      wr(8'h12 + 8'(i), PAT[i]);
    end
    wr(8'h1B, 8'h55);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00, 1'b1);
    chk("written lanes", want, lanes);
    for (int i = 0; i < 9; i++) rd(8'h12 + 8'(i), m[i], 1'b0);
    clk_en = 1'b0;
    wr(8'h16, 8'h00);
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    clk_en = 1'b1;
    chk("frozen lanes", want, lanes);
    // read and write of one byte in one cycle, then a back-to-back read
    @(negedge ref_clk);
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = {2'b11, 8'h16, 8'h5C};
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    chk("read beside write", {63'h0, m[4], 1'b1}, {63'h0, reg_rd_data, reg_rd_valid});
    m[4] = 8'h5C;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    chk("back to back read", {63'h0, m[4], 1'b1}, {63'h0, reg_rd_data, reg_rd_valid});
    chk("write beside read", want, lanes);
    rst_b = 1'b0;
    // expected word is a net: update it a cycle before it is compared
    for (int i = 0; i < 9; i++) m[i] = (i < 4) ? 8'h00 : 8'h88;
    @(negedge ref_clk);
    rst_b = 1'b1;
    chk("second reset", want, lanes);
    tally_and_finish();
  end
endmodule : ltld_regs_tb_top
